//--- verilog/spm_pkg.sv
// Package: constants, control, flag and pin types of the serial port
package spm_pkg;
    localparam int          SPM_DW        = 8;
    localparam int          SPM_FIFO_D    = 8;
    localparam logic [3:0]  SPM_LAST_EDGE = 4'hF;
    localparam logic [1:0]  SPM_SEL_3W    = 2'h0;
    localparam logic [1:0]  SPM_SEL_MULTI = 2'h1;
    localparam logic [1:0]  SPM_SEL_RST   = 2'h1;
    localparam logic [7:0]  SPM_DIV_RST   = 8'h03;
    // Bit positions in the port control register image
    localparam int          SPM_B_TC      = 7;
    localparam int          SPM_B_MASTER_ENABLE_BIT   = 6;
    localparam int          SPM_B_MODE_FAULT_FLAG    = 5;
    localparam int          SPM_B_OVR     = 4;
    localparam int          SPM_B_SELHI   = 3;
    localparam int          SPM_B_SELLO   = 2;
    localparam int          SPM_B_WRITE_COLLISION_FLAG    = 1;
    localparam int          SPM_B_PEN     = 0;

    typedef enum logic {SPM_IDLE, SPM_RUN} spm_state_t;

    typedef struct packed {
        logic       master_enable_bit;
        logic       port_enable_bit;
        logic [1:0] select_mode_field;
        logic       cpol;
        logic       cpha;
        logic [7:0] clk_div;
    } spm_ctrl_t;

    typedef struct packed {
        logic transfer_complete_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic receive_overrun_flag;
    } spm_flags_t;

    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
        logic nss;
    } spm_pins_t;

    localparam spm_ctrl_t SPM_CTRL_RST =
        '{1'b0, 1'b0, SPM_SEL_RST, 1'b0, 1'b0, SPM_DIV_RST};
    localparam spm_pins_t SPM_PINS_IDLE = 4'hF;
endpackage

//--- verilog/spm_port.sv
// Serial port master/slave engine with its transmit FIFO
// Summary of operation
// RULE_01: Bits shift most significant first, both directions, every mode.
// RULE_02: As master, master-out carries the shift register MSB.
// RULE_03: Slave-out released when port disabled or 4-wire slave unselected.
// RULE_04: 3-wire slave always drives slave-out from the shift register MSB.
// RULE_05: Unselected 4-wire slave ignores every serial clock edge.
// RULE_06: Select mode 00 is 3-wire; a slave counts as always selected.
// RULE_07: Mode 01: select is input; falling edge stops a master.
// RULE_08: Mode 1x: select is an output following the low mode bit.
// RULE_09: Select pin is routed only outside the 3-wire mode.
// RULE_10: Master mode entered when software sets master enable, bit 6.
// RULE_11: Data write fills transmit buffer; empty shifter takes it and starts.
// RULE_12: Master shifts loaded byte out at once while making the clock.
// RULE_13: Transfer complete flag, bit 7, sets at the end of each byte.
// RULE_14: Slave returns its byte simultaneously; one flag covers both directions.
// RULE_15: Completed received byte moves into the receive buffer for reading.
// RULE_16: Multi-master select low clears enables and sets the mode fault flag.
// RULE_17: After a mode fault only software re-enables the port.
// RULE_18: Upper mode bit, bit 3, makes a 4-wire single master.
// RULE_19: 4-wire slave active only while selected; select fall clears counter.
// RULE_20: Outside master lowers select two clocks before the first edge.
// RULE_21: Write while transmit buffer full is dropped and sets collision flag.
// RULE_22: Slave completion with unread receive byte drops it, sets overrun.
// RULE_23: Master gives eight clock cycles per byte from a divider, idles between.
// RULE_24: Both ends share polarity and phase; change them while disabled.
`timescale 1ns/1ps

module spm_fifo
#(
    parameter int W = 8,
    parameter int D = 8
)
(
    input  wire logic         i_sys_clk,  // System clock
    input  wire logic         i_rstn,     // Async reset, active low
    input  wire logic         i_valid,    // Write request
    output logic              o_ready,    // Space available
    input  wire logic [W-1:0] i_data,     // Write data
    output logic              o_valid,    // Data available
    input  wire logic         i_ready,    // Read acknowledge
    output logic [W-1:0]      o_data      // Oldest word
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } spm_fifo_st_t;

    spm_fifo_st_t r;
    spm_fifo_st_t next_r;
    logic         wr;
    logic         rd;

    function automatic logic [AW-1:0] spm_inc(input logic [AW-1:0] p);
        spm_inc = (p == AW'(D - 1)) ? '0 : p + AW'(1);
    endfunction

    assign o_ready = r.cnt != (AW + 1)'(D);
    assign o_valid = r.cnt != '0;
    assign o_data  = r.mem[r.rp];
    assign wr      = i_valid & o_ready;
    assign rd      = i_ready & o_valid;

    always_comb
    begin
        next_r = r;
        if (wr)
        begin
            next_r.mem[r.wp] = i_data;
            next_r.wp        = spm_inc(r.wp);
        end
        if (rd)
        begin
            next_r.rp = spm_inc(r.rp);
        end
        next_r.cnt = r.cnt + (AW + 1)'(wr) - (AW + 1)'(rd);
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            r <= '0;
        else
            r <= next_r;
    end
endmodule // spm_fifo

module spm_port
    import spm_pkg::*;
(
    input  wire logic        i_sys_clk,   // System clock, 100 MHz
    input  wire logic        i_rstn,      // Async reset, active low
    input  wire logic        i_ctrl_wr,   // Control write strobe
    input  wire spm_ctrl_t   i_ctrl,      // Control value to write
    input  wire spm_flags_t  i_flag_clr,  // Flag clear strobes
    input  wire logic        i_tx_valid,  // Data register write
    input  wire logic [7:0]  i_tx_data,   // Data register write value
    output logic             o_tx_ready,  // Transmit buffer has room
    input  wire logic        i_rx_read,   // Data register read
    output logic [7:0]       o_rx_data,   // Receive buffer
    output logic             o_rx_valid,  // Receive buffer holds byte
    output logic [7:0]       o_port_control_register, // Control image
    output logic             o_busy,      // Byte loaded or in flight
    input  wire spm_pins_t   i_pins,      // Pin levels from outside
    output spm_pins_t        o_pins,      // Pin drive levels
    output spm_pins_t        o_pins_oe,   // Pin output enables
    output logic             o_nss_routed // Select mapped to a pin
);
    typedef struct packed {
        spm_pins_t  sy1;
        spm_pins_t  sy2;
        logic       sck_prev;
        logic       nss_prev;
        spm_ctrl_t  ctrl;
        spm_flags_t flags;
        spm_state_t st;
        logic       loaded;
        logic [7:0] sr;
        logic       cap;
        logic [3:0] edge_cnt;
        logic [7:0] div_cnt;
        logic       sck_lvl;
        logic [7:0] rx_data;
        logic       rx_full;
    } spm_st_t;

    localparam spm_st_t ST_RST = '{sy1: SPM_PINS_IDLE,
        sy2: SPM_PINS_IDLE, nss_prev: 1'b1, ctrl: SPM_CTRL_RST,
        st: SPM_IDLE, default: '0};

    spm_st_t    r;
    spm_st_t    next_r;
    spm_pins_t  s;
    logic       is_m;
    logic       is_s;
    logic       multi;
    logic       sel;
    logic       nss_fall;
    logic       fault;
    logic       tick;
    logic       sedge;
    logic       step;
    logic       din;
    logic       smp;
    logic       skip;
    logic       last;
    logic       pop;
    logic       f_valid;
    logic [7:0] f_data;
    logic [7:0] byte_in;

    // Transmit buffer; a write that finds it full is dropped
    spm_fifo #(.W(SPM_DW), .D(SPM_FIFO_D)) u_txf (
        .i_sys_clk (i_sys_clk),
        .i_rstn    (i_rstn),
        .i_valid   (i_tx_valid),
        .o_ready   (o_tx_ready),
        .i_data    (i_tx_data),
        .o_valid   (f_valid),
        .i_ready   (pop),
        .o_data    (f_data)
    );

    assign s        = r.sy2;
    assign is_m     = r.ctrl.port_enable_bit & r.ctrl.master_enable_bit;
    assign is_s     = r.ctrl.port_enable_bit & !r.ctrl.master_enable_bit;
    assign multi    = r.ctrl.select_mode_field == SPM_SEL_MULTI;
    assign sel      = !multi | !s.nss;                       // [RULE_06]
    assign nss_fall = r.nss_prev & !s.nss;
    assign fault    = is_m & multi & nss_fall;               // [RULE_07]
    assign tick     = is_m & (r.st == SPM_RUN)
                    & (r.div_cnt == r.ctrl.clk_div);         // [RULE_23]
    assign sedge    = is_s & sel & (s.sck != r.sck_prev);    // [RULE_05]
    assign step     = tick | sedge;
    assign din      = is_m ? s.miso : s.mosi;                // [RULE_14]
    // Even edges sample with phase 0, odd edges with phase 1
    assign smp      = r.edge_cnt[0] == r.ctrl.cpha;
    assign skip     = r.ctrl.cpha & (r.edge_cnt == 4'h0);
    assign last     = r.edge_cnt == SPM_LAST_EDGE;
    assign byte_in  = {r.sr[6:0], smp ? din : r.cap};        // [RULE_01]
    // Load only between bytes so a slave never swaps data mid-byte
    // A byte popped in a control-write or fault cycle would be lost, so hold it back
    assign pop      = f_valid & !r.loaded & (r.st == SPM_IDLE)
                    & r.ctrl.port_enable_bit & !step
                    & !i_ctrl_wr & !fault;                   // [RULE_11]

    always_comb
    begin
        next_r          = r;
        next_r.sy1      = i_pins;
        next_r.sy2      = r.sy1;
        next_r.sck_prev = s.sck;
        next_r.nss_prev = s.nss;
        next_r.flags    = spm_flags_t'(r.flags & ~i_flag_clr);
        if (i_ctrl_wr)
            next_r.ctrl = i_ctrl;                            // [RULE_10]
        if (i_rx_read)
            next_r.rx_full = 1'b0;
        if (i_tx_valid & !o_tx_ready)
            next_r.flags.write_collision_flag = 1'b1;        // [RULE_21]
        if (pop)
        begin
            next_r.sr     = f_data;
            next_r.loaded = 1'b1;
            if (is_m)
            begin
                next_r.st      = SPM_RUN;                    // [RULE_12]
                next_r.div_cnt = 8'h00;
            end
        end
        case (r.st)
            SPM_IDLE:
                next_r.div_cnt = 8'h00;
            SPM_RUN:
                next_r.div_cnt = tick ? 8'h00 : r.div_cnt + 8'h01;
            default:
                next_r.st = SPM_IDLE;
        endcase
        if (step)
        begin
            next_r.st       = SPM_RUN;
            next_r.edge_cnt = r.edge_cnt + 4'h1;
            if (is_m)
                next_r.sck_lvl = !r.sck_lvl;                 // [RULE_23]
            if (smp)
                next_r.cap = din;
            else if (!skip)
                next_r.sr = {r.sr[6:0], r.cap};              // [RULE_01]
            if (last)
            begin
                next_r.st       = SPM_IDLE;
                next_r.edge_cnt = 4'h0;
                next_r.loaded   = 1'b0;
                next_r.sr       = byte_in;
                next_r.flags.transfer_complete_flag = 1'b1;  // [RULE_13]
                if (is_s & r.rx_full & !i_rx_read)
                    next_r.flags.receive_overrun_flag = 1'b1; // [RULE_22]
                else
                begin
                    next_r.rx_data = byte_in;                // [RULE_15]
                    next_r.rx_full = 1'b1;
                end
            end
        end
        // Stopping mid-byte is the only way to resync a 3-wire slave
        if (!r.ctrl.port_enable_bit | fault | i_ctrl_wr
            | (is_s & multi & nss_fall))                     // [RULE_19]
        begin
            next_r.st       = SPM_IDLE;
            next_r.edge_cnt = 4'h0;
            next_r.sck_lvl  = 1'b0;
            // Drop the aborted byte, else the shifter never reloads
            next_r.loaded   = 1'b0;
        end
        if (fault)
        begin
            next_r.ctrl.master_enable_bit = 1'b0;            // [RULE_16]
            next_r.ctrl.port_enable_bit   = 1'b0;            // [RULE_17]
            next_r.flags.mode_fault_flag  = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            r <= ST_RST;
        else
            r <= next_r;
    end

    assign o_pins.sck     = r.ctrl.cpol ^ r.sck_lvl;         // [RULE_24]
    assign o_pins.mosi    = r.sr[7];                         // [RULE_02]
    assign o_pins.miso    = r.sr[7];                         // [RULE_04]
    assign o_pins.nss     = r.ctrl.select_mode_field[0];     // [RULE_08]
    assign o_pins_oe.sck  = is_m;
    assign o_pins_oe.mosi = is_m;
    assign o_pins_oe.miso = is_s & sel;                      // [RULE_03]
    assign o_pins_oe.nss  = r.ctrl.select_mode_field[1];     // [RULE_18]
    assign o_nss_routed   = r.ctrl.select_mode_field != SPM_SEL_3W; // [RULE_09]
    assign o_rx_data      = r.rx_data;
    assign o_rx_valid     = r.rx_full;
    assign o_busy         = (r.st == SPM_RUN) | r.loaded;

    assign o_port_control_register[SPM_B_TC]    =
        r.flags.transfer_complete_flag;
    assign o_port_control_register[SPM_B_MASTER_ENABLE_BIT] = r.ctrl.master_enable_bit;
    assign o_port_control_register[SPM_B_MODE_FAULT_FLAG]  = r.flags.mode_fault_flag;
    assign o_port_control_register[SPM_B_OVR]   =
        r.flags.receive_overrun_flag;
    assign o_port_control_register[SPM_B_SELHI] =
        r.ctrl.select_mode_field[1];
    assign o_port_control_register[SPM_B_SELLO] =
        r.ctrl.select_mode_field[0];
    assign o_port_control_register[SPM_B_WRITE_COLLISION_FLAG]  =
        r.flags.write_collision_flag;
    assign o_port_control_register[SPM_B_PEN]   = r.ctrl.port_enable_bit;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_fault;
        fault;
    endsequence

    sequence s_stopped;
        !r.ctrl.port_enable_bit && !r.ctrl.master_enable_bit
        && r.flags.mode_fault_flag;
    endsequence

    sequence s_master_load;
        pop && is_m;
    endsequence

    shift_order_a: assert property ( // [RULE_01]
        (step && !smp && !skip && !last && !i_ctrl_wr && !fault)
        |=> r.sr[7:1] == $past(r.sr[6:0]))
        else $error("shift register did not move toward the MSB");
    mosi_drive_a: assert property ( // [RULE_02]
        is_m |-> o_pins_oe.mosi && o_pins.mosi == r.sr[7])
        else $error("master-out not driven from shift MSB");
    miso_release_a: assert property ( // [RULE_03]
        (!r.ctrl.port_enable_bit || (is_s && multi && s.nss))
        |-> !o_pins_oe.miso)
        else $error("slave-out driven while it must float");
    miso_3wire_a: assert property ( // [RULE_04]
        (is_s && r.ctrl.select_mode_field == SPM_SEL_3W)
        |-> o_pins_oe.miso)
        else $error("3-wire slave not driving slave-out");
    sck_ignore_a: assert property ( // [RULE_05]
        (is_s && multi && s.nss && !i_ctrl_wr) |=> $stable(r.edge_cnt))
        else $error("unselected slave counted a clock edge");
    nss_output_a: assert property ( // [RULE_08]
        r.ctrl.select_mode_field[1]
        |-> o_pins_oe.nss && o_pins.nss == r.ctrl.select_mode_field[0])
        else $error("select output does not follow the mode bit");
    master_start_a: assert property ( // [RULE_12]
        s_master_load ##0 (!fault && !i_ctrl_wr)
        |=> r.st == SPM_RUN && o_pins_oe.sck)
        else $error("master did not start after loading");
    done_flag_a: assert property ( // [RULE_13]
        (step && last && !fault && !i_ctrl_wr)
        |=> r.flags.transfer_complete_flag && r.st == SPM_IDLE)
        else $error("completion flag missing after last edge");
    mode_fault_a: assert property ( // [RULE_16]
        s_fault |=> s_stopped)
        else $error("mode fault did not stop the port");
    no_resume_a: assert property ( // [RULE_17]
        (!r.ctrl.port_enable_bit && !i_ctrl_wr)
        |=> !r.ctrl.port_enable_bit)
        else $error("port enabled itself");
    overrun_keep_a: assert property ( // [RULE_22]
        (step && last && is_s && r.rx_full && !i_rx_read && !fault)
        |=> r.flags.receive_overrun_flag && $stable(r.rx_data))
        else $error("overrun byte not dropped");
    sck_idle_a: assert property ( // [RULE_23]
        (is_m && r.st == SPM_IDLE) [*2] |-> o_pins.sck == r.ctrl.cpol)
        else $error("serial clock not idle between bytes");
endmodule // spm_port

//--- sim/spm_partner.sv
// Far-side serial device model: slave responder and link master
`timescale 1ns/1ps
module spm_partner
(
    input  wire logic i_sck,   // Resolved clock pin
    input  wire logic i_mosi,  // Resolved master-out pin
    input  wire logic i_miso,  // Resolved slave-out pin
    input  wire logic i_cpol,  // Idle clock level in use
    output logic      o_sck,   // Clock driven as master
    output logic      o_mosi,  // Data driven as master
    output logic      o_miso,  // Data driven as slave
    output logic      o_nss_n  // Select driven toward the port
);
    logic [7:0] tx_sr;
    logic [7:0] rx_sr;
    int         edges;
    initial
    begin
        {o_sck, o_mosi, o_miso, o_nss_n} = 4'h1;
        edges = 0;
    end
    task automatic load(input logic [7:0] b);
    begin
        tx_sr  = b;
        o_miso = b[7];
        edges  = 0;
    end
    endtask
    // Leading edge samples, trailing edge shifts
    always @(i_sck)
    begin
        edges = edges + 1;
        if (i_sck != i_cpol)
            rx_sr = {rx_sr[6:0], i_mosi};
        else if (edges < 16)
        begin
            tx_sr  = {tx_sr[6:0], 1'b0};
            o_miso = tx_sr[7];
        end
        else
            o_miso = ~o_miso; // Inverted: no stale level
    end
    // Clock stands still outside frames; cpol 0, phase 0 only
    task automatic send(input logic [7:0] b, input logic sel,
                        output logic [7:0] got);
        int i;
    begin
        o_nss_n = ~sel;
        #30; // Select leads the first edge by 92.5 ns
        for (i = 7; i >= 0; i--)
        begin
            o_mosi = b[i];
            #62.5 o_sck = 1'b1;
            got[i] = i_miso;
            #62.5 o_sck = 1'b0;
        end
        o_mosi = ~o_mosi;
        #62.5 o_nss_n = 1'b1;
    end
    endtask
endmodule // spm_partner

//--- sim/spm_port_tb_top.sv
// Self-checking bench of the serial port against a far-side model
`timescale 1ns/1ps
module spm_port_tb_top
    import spm_pkg::*;
;
    typedef struct packed {
        logic [1:0] mode;
        logic       cpol;
        logic [7:0] div;
        logic [7:0] tx;
        logic [7:0] rep;
    } spm_row_t;
    spm_row_t   rows [4] = '{'{2'h0, 1'b0, 8'h03, 8'hA5, 8'h3C},
                             '{2'h1, 1'b1, 8'h05, 8'h80, 8'h01},
                             '{2'h2, 1'b0, 8'h03, 8'hFF, 8'h00},
                             '{2'h3, 1'b1, 8'h04, 8'h01, 8'hFE}};
    spm_row_t   rw;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       ctrl_wr = 1'b0;
    spm_ctrl_t  ctrl = SPM_CTRL_RST;
    spm_flags_t flag_clr = 4'h0;
    logic       tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic       rx_read = 1'b0;
    logic       tx_ready, rx_valid, busy, nss_routed;
    logic [7:0] rx_data, image, got;
    spm_pins_t  pin_in, pin_out, pin_oe;
    logic       p_sck, p_mosi, p_miso, p_nss_n;
    int         num_errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         k;

    // Each pin takes the port's level while it drives, else the model's
    assign pin_in = {pin_oe.sck ? pin_out.sck : p_sck,
                     pin_oe.mosi ? pin_out.mosi : p_mosi,
                     pin_oe.miso ? pin_out.miso : p_miso,
                     pin_oe.nss ? pin_out.nss : p_nss_n};

    spm_port u_dut (.i_sys_clk(clk), .i_rstn(rstn), .i_ctrl_wr(ctrl_wr),
        .i_ctrl(ctrl), .i_flag_clr(flag_clr), .i_tx_valid(tx_valid),
        .i_tx_data(tx_data), .o_tx_ready(tx_ready), .i_rx_read(rx_read),
        .o_rx_data(rx_data), .o_rx_valid(rx_valid),
        .o_port_control_register(image), .o_busy(busy), .i_pins(pin_in),
        .o_pins(pin_out), .o_pins_oe(pin_oe), .o_nss_routed(nss_routed));
    spm_partner u_partner (.i_sck(pin_in.sck), .i_mosi(pin_in.mosi),
        .i_miso(pin_in.miso), .i_cpol(ctrl.cpol), .o_sck(p_sck),
        .o_mosi(p_mosi), .o_miso(p_miso), .o_nss_n(p_nss_n));

    always #5 clk = ~clk;

    task automatic stop_test;
    begin
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    // Ceiling well above the roughly 1100 cycles the tests need
    always @(posedge clk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            stop_test;
        end
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
    begin
        cmp_count++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    task automatic tick;
    begin
        @(posedge clk);
        #1;
    end
    endtask
    task automatic wr_ctrl(input logic m, p, input logic [1:0] md,
                           input logic cp, input logic [7:0] dv);
    begin
        @(posedge clk);
        ctrl_wr <= 1'b1;
        ctrl    <= '{m, p, md, cp, 1'b0, dv};
        @(posedge clk);
        ctrl_wr <= 1'b0;
        #1;
    end
    endtask
    task automatic put(input logic [7:0] b);
    begin
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= b;
        @(posedge clk);
        tx_valid <= 1'b0;
        #1;
    end
    endtask
    task automatic clr(input logic rd, input spm_flags_t f);
    begin
        @(posedge clk);
        rx_read  <= rd;
        flag_clr <= f;
        @(posedge clk);
        rx_read  <= 1'b0;
        flag_clr <= 4'h0;
        #1;
    end
    endtask

    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        tick;
        chk("image", 8'h04, image);
        chk("pin_oe", 8'h00, {4'h0, pin_oe});
        chk("ready_valid", 8'h02, {tx_ready, rx_valid});
        chk("nss_routed", 8'h01, {7'h0, nss_routed});
        $display("reset test done");
        for (int r = 0; r < 4; r++)
        begin
            rw = rows[r];
            wr_ctrl(1'b0, 1'b0, rw.mode, rw.cpol, rw.div);
            wr_ctrl(1'b1, 1'b1, rw.mode, rw.cpol, rw.div);
            chk("image", {4'h4, rw.mode, 2'h1}, image);
            chk("routed", {7'h0, |rw.mode}, {7'h0, nss_routed});
            chk("nss_oe", {7'h0, rw.mode[1]}, {7'h0, pin_oe.nss});
            if (rw.mode[1])
                chk("nss", {7'h0, rw.mode[0]},
                    {7'h0, pin_out.nss});
            u_partner.load(rw.rep);
            put(rw.tx);
            for (k = 0; k < 20 && busy !== 1'b1; k++) tick;
            chk("mosi", {7'h0, rw.tx[7]},
                {7'h0, pin_out.mosi});
            for (k = 0; k < 900 && rx_valid !== 1'b1; k++) tick;
            chk("rx_data", rw.rep, rx_data);
            chk("far_rx", rw.tx, u_partner.rx_sr);
            chk("done", 8'h01, {7'h0, image[7]});
            chk("edges", 8'h10, u_partner.edges[7:0]);
            chk("sck_idle", {7'h0, rw.cpol}, {7'h0, pin_out.sck});
            clr(1'b1, 4'h8);
            chk("done_clr", 8'h00, {7'h0, image[7]});
        end
        $display("row tests done");
        wr_ctrl(1'b1, 1'b1, SPM_SEL_3W, 1'b0, 8'h01);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= 8'h5C;
        #1;
        for (k = 0; k < 20 && tx_ready === 1'b1; k++) tick;
        @(posedge clk);
        tx_valid <= 1'b0;
        tick;
        chk("collision", 8'h01, {7'h0, image[1]});
        // Busy dips for a cycle between bytes; wait for the FIFO too
        for (k = 0; k < 900 && (busy !== 1'b0 || u_dut.f_valid !== 1'b0);
             k++) tick;
        chk("drained", 8'h01, {7'h0, tx_ready});
        clr(1'b1, 4'hC);
        chk("col_clr", 8'h00, {7'h0, image[1]});
        $display("collision test done");
        wr_ctrl(1'b1, 1'b1, SPM_SEL_MULTI, 1'b0, 8'h03);
        u_partner.o_nss_n = 1'b0;
        repeat (6) tick;
        chk("fault", 8'h24, image);
        chk("sck_oe", 8'h00, {7'h0, pin_oe.sck});
        u_partner.o_nss_n = 1'b1;
        repeat (10) tick;
        chk("no_resume", 8'h24, image);
        clr(1'b0, 4'h2);
        chk("fault_clr", 8'h04, image);
        $display("mode fault test done");
        wr_ctrl(1'b0, 1'b1, SPM_SEL_MULTI, 1'b0, 8'h03);
        put(8'hC3);
        repeat (4) tick;
        chk("miso_oe", 8'h00, {7'h0, pin_oe.miso});
        u_partner.send(8'h5A, 1'b0, got);
        tick;
        chk("unselected", 8'h00, {7'h0, rx_valid});
        u_partner.send(8'h96, 1'b1, got);
        repeat (4) tick;
        chk("slave_rx", 8'h96, rx_data);
        chk("slave_tx", 8'hC3, got);
        u_partner.send(8'h77, 1'b1, got);
        repeat (4) tick;
        chk("overrun", 8'h01, {7'h0, image[4]});
        chk("kept", 8'h96, rx_data);
        clr(1'b1, 4'h9);
        chk("ovr_clr", 8'h00, {7'h0, image[4]});
        wr_ctrl(1'b0, 1'b1, SPM_SEL_3W, 1'b0, 8'h03);
        chk("miso_3w", 8'h01, {7'h0, pin_oe.miso});
        chk("routed_3w", 8'h00, {7'h0, nss_routed});
        wr_ctrl(1'b0, 1'b0, SPM_SEL_3W, 1'b0, 8'h03);
        chk("miso_off", 8'h00, {7'h0, pin_oe.miso});
        $display("slave test done");
        stop_test;
    end
endmodule // spm_port_tb_top
